// >>> pdc_pkg.sv
// Constants, encodings and state types shared by the pump drive command parser.
package pdc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYC = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam int CNT_W = 14;
    localparam logic [9:0] FREQ_MAX = 10'h12c;
    localparam logic [9:0] FREQ_CMD_MIN = 10'h001;
    localparam logic [10:0] AMP_MAX_H = 11'h1f4;
    localparam logic [10:0] AMP_CMD_MIN_H = 11'h00a;
    localparam logic [9:0] DIGIT3_LIMIT = 10'h064;
    localparam logic [3:0] FRAC_HALF = 4'h5;
    localparam int BTN_N = 7;
    localparam int BTN_POWER = 0;
    localparam int BTN_STORE = 1;
    localparam int BTN_WAVE = 2;
    localparam int BTN_FUP = 3;
    localparam int BTN_FDN = 4;
    localparam int BTN_AUP = 5;
    localparam int BTN_ADN = 6;
    localparam logic [1:0] STEPPED_WAVE_SHAPE = 2'h0;
    localparam logic [1:0] SQUARE_WAVE_SELECT = 2'h1;
    localparam logic [1:0] SINE_SELECT = 2'h2;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_5 = 8'h35;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_UA = 8'h41;
    localparam logic [7:0] CH_UB = 8'h42;
    localparam logic [7:0] CH_UC = 8'h43;
    localparam logic [7:0] CH_UF = 8'h46;
    localparam logic [7:0] CH_UM = 8'h4d;
    localparam logic [7:0] CH_UR = 8'h52;
    localparam logic [7:0] CH_US = 8'h53;
    localparam logic [7:0] CH_LB = 8'h62;
    localparam logic [7:0] CH_LF_LETTER = 8'h66;
    localparam logic [7:0] CH_LN = 8'h6e;
    localparam logic [7:0] CH_LO = 8'h6f;
    localparam logic [4:0] REPORT_LAST = 5'h12;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SETTING = 4'h8;
    localparam int CTRL_SERIAL_EN = 0;
    localparam int CTRL_PANEL_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int SET_AMP_LSB = 16;

    typedef enum logic [3:0] {
        P_EMPTY, P_B, P_BO, P_BON, P_BOF, P_BOFF, P_F, P_FNUM,
        P_A, P_AINT, P_ACOMMA, P_AFRAC, P_M, P_MWAVE, P_BAD
    } pdc_parse_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} pdc_rx_e;
endpackage : pdc_pkg

// >>> pdc_pump_drive_command_parser.sv
// Front panel and serial command control of the pump driver settings.
`timescale 1ns/1ns
// Functional notes
// - Power button press toggles pump drive and lamp together.
// - Store button press writes frequency, amplitude, waveform to retained storage.
// - Frequency rocker steps setting up or down, held within 0 to 300 Hz.
// - Waveform button cycles stepped, rectangular, sine.
// - Amplitude rocker steps setting up or down, held within 0 to 250 V.
// - Serial link runs 9600 baud, eight data bits, no parity, one stop.
// - Commands end with enter; buffered command acts only on that terminator.
// - Command bon starts pump drive with current settings.
// - Command boff stops pump drive.
// - Command F with decimal 1 to 300 loads drive frequency in hertz.
// - Command A with decimal 5 to 250 loads drive amplitude in volts.
// - Amplitude may carry comma fraction; resolution is half a volt.
// - Two-letter M commands select sine, rectangle or stepped waveform.
// - Bare terminator sends report of frequency, amplitude, waveform, run state.
// - Settings are independent and change while running without stopping.
module pdc_pump_drive_command_parser
    import pdc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
) (
    input  wire logic sys_clk_i,           // System clock, 100 MHz.
    input  wire logic srst_i,              // Synchronous reset, active high.
    input  wire logic [BTN_N-1:0] btn_i,   // Panel buttons, high while pressed.
    input  wire logic uart_rx_i,           // Serial receive pin from the host.
    output logic uart_tx_o,                // Serial transmit pin to the host.
    input  wire logic [8:0] nvm_freq_i,    // Retained frequency, hertz.
    input  wire logic [8:0] nvm_amp_i,     // Retained amplitude, half volts.
    input  wire logic [1:0] nvm_wave_i,    // Retained waveform code.
    output logic nvm_wr_o,                 // Pulse: store present settings.
    output logic [8:0] freq_o,             // Drive frequency, hertz.
    output logic [8:0] amp_o,              // Drive amplitude, half volts.
    output logic [1:0] wave_o,             // Waveform code.
    output logic pump_run_o,               // Pump drive running.
    output logic lamp_o,                   // Panel indicator lamp.
    input  wire logic [3:0] reg_addr_i,    // Register byte address.
    input  wire logic [31:0] reg_wdata_i,  // Register write data.
    input  wire logic reg_wr_i,            // Register write strobe.
    input  wire logic reg_rd_i,            // Register read strobe.
    output logic [31:0] reg_rdata_o        // Read data, cycle after the strobe.
);
    function automatic logic is_digit(input logic [7:0] c);
        return (c >= CH_0) && (c <= CH_9);
    endfunction : is_digit

    function automatic logic [11:0] dec3(input logic [9:0] v);
        logic [9:0] h;
        logic [9:0] t;
        logic [9:0] u;
        h = v / 10'd100;
        t = (v / 10'd10) % 10'd10;
        u = v % 10'd10;
        return {h[3:0], t[3:0], u[3:0]};
    endfunction : dec3

    logic [1:0] ctrl_r;
    logic [BTN_N-1:0] btn_s1_r, btn_s2_r, btn_s3_r, btn_lvl_r, btn_prev_r;
    logic [BTN_N-1:0] press;
    logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
    pdc_rx_e rx_st_r;
    logic [CNT_W-1:0] rx_cnt_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_vld_r;
    logic [7:0] rx_byte_r;
    pdc_parse_e pst_r;
    logic [9:0] acc_r;
    logic frac_r;
    logic [1:0] mwave_r;
    logic exec;
    logic [10:0] amp_cmd;
    logic do_on, do_off, do_freq, do_amp, do_wave, do_report;
    logic [8:0] freq_r, amp_r;
    logic [1:0] wave_r;
    logic run_r;
    logic restore_r;
    logic rep_busy_r;
    logic [4:0] rep_idx_r;
    logic [11:0] rep_f_r, rep_a_r;
    logic rep_frac_r, rep_run_r;
    logic [1:0] rep_wave_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_bit_r;
    logic [CNT_W-1:0] tx_cnt_r;
    logic tx_busy_r;
    logic [7:0] rep_char;

    // Three stages per pin; a level is taken only when stages two and three agree.
    always_ff @(posedge sys_clk_i) begin
        btn_s1_r <= btn_i;
        btn_s2_r <= btn_s1_r;
        btn_s3_r <= btn_s2_r;
        rx_s1_r <= uart_rx_i;
        rx_s2_r <= rx_s1_r;
        rx_s3_r <= rx_s2_r;
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            btn_lvl_r <= '0;
            btn_prev_r <= '0;
            rx_lvl_r <= 1'b1;
        end else begin
            for (int i = 0; i < BTN_N; i++) begin
                if (btn_s2_r[i] == btn_s3_r[i]) begin
                    btn_lvl_r[i] <= btn_s3_r[i];
                end
            end
            btn_prev_r <= btn_lvl_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_lvl_r <= rx_s3_r;
            end
        end
    end

    assign press = (btn_lvl_r & ~btn_prev_r) & {BTN_N{ctrl_r[CTRL_PANEL_EN]}};

    // Receiver samples mid-bit; a byte with a low stop bit is dropped.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_sh_r <= '0;
            rx_vld_r <= 1'b0;
            rx_byte_r <= '0;
        end else begin
            rx_vld_r <= 1'b0;
            if (rx_cnt_r != '0) begin
                rx_cnt_r <= rx_cnt_r - 1'b1;
            end
            case (rx_st_r)
                RX_IDLE: begin
                    if (!rx_lvl_r) begin
                        rx_st_r <= RX_START;
                        rx_cnt_r <= CNT_W'(BIT_CYCLES / 2);
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == '0) begin
                        rx_st_r <= rx_lvl_r ? RX_IDLE : RX_DATA;
                        rx_cnt_r <= CNT_W'(BIT_CYCLES - 1);
                        rx_bit_r <= '0;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_r == '0) begin
                        rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
                        rx_cnt_r <= CNT_W'(BIT_CYCLES - 1);
                        rx_bit_r <= rx_bit_r + 1'b1;
                        if (rx_bit_r == 3'h7) begin
                            rx_st_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_r == '0) begin
                        rx_vld_r <= rx_lvl_r;
                        rx_byte_r <= rx_sh_r;
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Characters are parsed as they arrive; nothing acts before the terminator.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pst_r <= P_EMPTY;
            acc_r <= '0;
            frac_r <= 1'b0;
            mwave_r <= STEPPED_WAVE_SHAPE;
        end else if (rx_vld_r && rx_byte_r == CH_CR) begin
            pst_r <= P_EMPTY;
            acc_r <= '0;
            frac_r <= 1'b0;
        end else if (rx_vld_r && rx_byte_r != CH_LF) begin
            case (pst_r)
                P_EMPTY: begin
                    case (rx_byte_r)
                        CH_LB: pst_r <= P_B;
                        CH_UF: pst_r <= P_F;
                        CH_UA: pst_r <= P_A;
                        CH_UM: pst_r <= P_M;
                        default: pst_r <= P_BAD;
                    endcase
                end
                P_B: pst_r <= (rx_byte_r == CH_LO) ? P_BO : P_BAD;
                P_BO: begin
                    if (rx_byte_r == CH_LN) begin
                        pst_r <= P_BON;
                    end else begin
                        pst_r <= (rx_byte_r == CH_LF_LETTER) ? P_BOF : P_BAD;
                    end
                end
                P_BOF: pst_r <= (rx_byte_r == CH_LF_LETTER) ? P_BOFF : P_BAD;
                P_F, P_FNUM, P_A, P_AINT: begin
                    if (is_digit(rx_byte_r) && acc_r < DIGIT3_LIMIT) begin
                        acc_r <= 10'((acc_r * 10'd10) + {2'h0, rx_byte_r - CH_0});
                        pst_r <= (pst_r == P_F || pst_r == P_FNUM) ? P_FNUM : P_AINT;
                    end else if (rx_byte_r == CH_COMMA && pst_r == P_AINT) begin
                        pst_r <= P_ACOMMA;
                    end else begin
                        pst_r <= P_BAD;
                    end
                end
                P_ACOMMA: begin
                    if (is_digit(rx_byte_r)) begin
                        frac_r <= (rx_byte_r - CH_0) >= 8'(FRAC_HALF);
                        pst_r <= P_AFRAC;
                    end else begin
                        pst_r <= P_BAD;
                    end
                end
                P_AFRAC: pst_r <= is_digit(rx_byte_r) ? P_AFRAC : P_BAD;
                P_M: begin
                    pst_r <= P_MWAVE;
                    case (rx_byte_r)
                        CH_US: mwave_r <= SINE_SELECT;
                        CH_UR: mwave_r <= SQUARE_WAVE_SELECT;
                        CH_UC: mwave_r <= STEPPED_WAVE_SHAPE;
                        default: pst_r <= P_BAD;
                    endcase
                end
                default: pst_r <= P_BAD;
            endcase
        end
    end

    assign exec = rx_vld_r && (rx_byte_r == CH_CR) && ctrl_r[CTRL_SERIAL_EN];
    assign amp_cmd = {acc_r, 1'b0} + {10'h0, frac_r};
    assign do_on = exec && pst_r == P_BON;
    assign do_off = exec && pst_r == P_BOFF;
    assign do_freq = exec && pst_r == P_FNUM && acc_r >= FREQ_CMD_MIN
                     && acc_r <= FREQ_MAX;
    assign do_amp = exec && (pst_r == P_AINT || pst_r == P_ACOMMA || pst_r == P_AFRAC)
                    && amp_cmd >= AMP_CMD_MIN_H && amp_cmd <= AMP_MAX_H;
    assign do_wave = exec && pst_r == P_MWAVE;
    assign do_report = exec && pst_r == P_EMPTY;

    // Each setting has its own register; none of them touches the run state.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            restore_r <= 1'b1;
            freq_r <= '0;
        end else begin
            restore_r <= 1'b0;
            if (restore_r) begin
                if ({1'b0, nvm_freq_i} <= FREQ_MAX) begin
                    freq_r <= nvm_freq_i;
                end
            end else if (do_freq) begin
                freq_r <= acc_r[8:0];
            end else if (press[BTN_FUP] && {1'b0, freq_r} < FREQ_MAX) begin
                freq_r <= freq_r + 1'b1;
            end else if (press[BTN_FDN] && freq_r != '0) begin
                freq_r <= freq_r - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            amp_r <= '0;
        end else if (restore_r) begin
            if ({2'h0, nvm_amp_i} <= AMP_MAX_H) begin
                amp_r <= nvm_amp_i;
            end
        end else if (do_amp) begin
            amp_r <= amp_cmd[8:0];
        end else if (press[BTN_AUP] && {2'h0, amp_r} < AMP_MAX_H) begin
            amp_r <= amp_r + 1'b1;
        end else if (press[BTN_ADN] && amp_r != '0) begin
            amp_r <= amp_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wave_r <= STEPPED_WAVE_SHAPE;
        end else if (restore_r) begin
            if (nvm_wave_i <= SINE_SELECT) begin
                wave_r <= nvm_wave_i;
            end
        end else if (do_wave) begin
            wave_r <= mwave_r;
        end else if (press[BTN_WAVE]) begin
            wave_r <= (wave_r == SINE_SELECT) ? STEPPED_WAVE_SHAPE : wave_r + 1'b1;
        end
    end

    // Power-up leaves the pump stopped whatever storage holds.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            run_r <= 1'b0;
            nvm_wr_o <= 1'b0;
        end else begin
            if (do_on) begin
                run_r <= 1'b1;
            end else if (do_off) begin
                run_r <= 1'b0;
            end else if (press[BTN_POWER]) begin
                run_r <= ~run_r;
            end
            nvm_wr_o <= press[BTN_STORE] && !restore_r;
        end
    end

    // A report asked for while one is still going out is dropped.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rep_busy_r <= 1'b0;
            rep_idx_r <= '0;
            rep_f_r <= '0;
            rep_a_r <= '0;
            rep_frac_r <= 1'b0;
            rep_run_r <= 1'b0;
            rep_wave_r <= STEPPED_WAVE_SHAPE;
        end else if (do_report && !rep_busy_r) begin
            rep_busy_r <= 1'b1;
            rep_idx_r <= '0;
            rep_f_r <= dec3({1'b0, freq_r});
            rep_a_r <= dec3({2'h0, amp_r[8:1]});
            rep_frac_r <= amp_r[0];
            rep_run_r <= run_r;
            rep_wave_r <= wave_r;
        end else if (rep_busy_r && !tx_busy_r) begin
            rep_idx_r <= rep_idx_r + 1'b1;
            if (rep_idx_r == REPORT_LAST) begin
                rep_busy_r <= 1'b0;
            end
        end
    end

    // Report text: Fddd Addd,d Mw Br, then carriage return and line feed.
    always_comb begin
        rep_char = CH_SP;
        case (rep_idx_r)
            5'h00: rep_char = CH_UF;
            5'h01: rep_char = CH_0 | {4'h0, rep_f_r[11:8]};
            5'h02: rep_char = CH_0 | {4'h0, rep_f_r[7:4]};
            5'h03: rep_char = CH_0 | {4'h0, rep_f_r[3:0]};
            5'h05: rep_char = CH_UA;
            5'h06: rep_char = CH_0 | {4'h0, rep_a_r[11:8]};
            5'h07: rep_char = CH_0 | {4'h0, rep_a_r[7:4]};
            5'h08: rep_char = CH_0 | {4'h0, rep_a_r[3:0]};
            5'h09: rep_char = CH_COMMA;
            5'h0a: rep_char = rep_frac_r ? CH_5 : CH_0;
            5'h0c: rep_char = CH_UM;
            5'h0d: rep_char = (rep_wave_r == SINE_SELECT) ? CH_US :
                              (rep_wave_r == SQUARE_WAVE_SELECT) ? CH_UR : CH_UC;
            5'h0f: rep_char = CH_UB;
            5'h10: rep_char = rep_run_r ? CH_1 : CH_0;
            5'h11: rep_char = CH_CR;
            5'h12: rep_char = CH_LF;
            default: rep_char = CH_SP;
        endcase
    end

    // Transmitter: start bit, eight data bits LSB first, one stop bit.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
            tx_bit_r <= '0;
            tx_cnt_r <= '0;
        end else if (!tx_busy_r) begin
            if (rep_busy_r) begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= {1'b1, rep_char, 1'b0};
                tx_bit_r <= '0;
                tx_cnt_r <= CNT_W'(BIT_CYCLES - 1);
            end
        end else if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
        end else begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_cnt_r <= CNT_W'(BIT_CYCLES - 1);
            tx_bit_r <= tx_bit_r + 1'b1;
            if (tx_bit_r == 4'h9) begin
                tx_busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_r <= CTRL_RESET;
            reg_rdata_o <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_CTRL) begin
                ctrl_r <= reg_wdata_i[1:0];
            end
            reg_rdata_o <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    REG_CTRL: reg_rdata_o <= {30'h0, ctrl_r};
                    REG_STATUS: reg_rdata_o <= {28'h0, wave_r, rep_busy_r, run_r};
                    REG_SETTING: reg_rdata_o <= {7'h0, amp_r, 7'h0, freq_r};
                    default: reg_rdata_o <= '0;
                endcase
            end
        end
    end

    assign uart_tx_o = tx_sh_r[0];
    assign freq_o = freq_r;
    assign amp_o = amp_r;
    assign wave_o = wave_r;
    assign pump_run_o = run_r;
    assign lamp_o = run_r;
endmodule : pdc_pump_drive_command_parser

// >>> pdc_checker_properties.sv
// Concurrent checks on the ports of the pump drive command parser.
`timescale 1ns/1ns
module pdc_checker
    import pdc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYC
) (
    input wire logic sys_clk_i, // Clock.
    input wire logic srst_i, // Reset.
    input wire logic uart_tx_o, // Serial out.
    input wire logic nvm_wr_o, // Store pulse.
    input wire logic [8:0] freq_o, // Frequency.
    input wire logic [8:0] amp_o, // Amplitude.
    input wire logic [1:0] wave_o, // Waveform.
    input wire logic pump_run_o, // Run state.
    input wire logic lamp_o // Lamp.
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic [15:0] low_cnt_r;
    // Counts the low run of the serial output so bit width can be judged on the rise.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || uart_tx_o) begin
            low_cnt_r <= 16'h0;
        end else begin
            low_cnt_r <= low_cnt_r + 16'h1;
        end
    end
    lamp_follows_a: assert property (lamp_o == pump_run_o)
        else $error("lamp differs from run state");
    store_pulse_a: assert property (nvm_wr_o |=> !nvm_wr_o)
        else $error("store pulse longer than one cycle");
    freq_limit_a: assert property ({1'b0, freq_o} <= FREQ_MAX)
        else $error("frequency above limit");
    amp_limit_a: assert property ({2'h0, amp_o} <= AMP_MAX_H)
        else $error("amplitude above limit");
    wave_code_a: assert property (wave_o != 2'h3)
        else $error("waveform code unused value");
    bit_width_a: assert property ($rose(uart_tx_o) |-> low_cnt_r >= 16'(BIT_CYCLES - 1))
        else $error("serial low time shorter than a bit");
    tx_idle_a: assert property ($fell(srst_i) |-> uart_tx_o)
        else $error("serial output not idle after reset");
    start_stopped_a: assert property ($fell(srst_i) |-> !pump_run_o [*2])
        else $error("pump running after reset");
    run_undisturbed_a: assert property (
        $changed(freq_o) || $changed(amp_o) || $changed(wave_o) |-> $stable(pump_run_o))
        else $error("setting change altered run state");
    cover property ($rose(pump_run_o));
    cover property (nvm_wr_o);
    cover property ($fell(uart_tx_o));
endmodule : pdc_checker
bind pdc_pump_drive_command_parser pdc_checker #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .uart_tx_o(uart_tx_o), .nvm_wr_o(nvm_wr_o),
    .freq_o(freq_o), .amp_o(amp_o), .wave_o(wave_o), .pump_run_o(pump_run_o),
    .lamp_o(lamp_o));

// >>> pdc_host_model.sv
// Host terminal model: sends command text and collects report characters.
`timescale 1ns/1ns
module pdc_host_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk_i, // System clock.
    input wire logic rx_i, // Report line from the device.
    output logic tx_o // Command line to the device.
);
    int rx_cnt = 0;
    logic [7:0] rx_byte;
    logic [7:0] rx_first;
    logic [7:0] rx_last;
    logic [7:0] rx_buf [32];
    initial tx_o = 1'b1;
    task automatic send_str(input string s);
        logic [9:0] fr;
        for (int c = 0; c < s.len(); c++) begin
            fr = {1'b1, 8'(s[c]), 1'b0};
            for (int i = 0; i < 10; i++) begin
                @(posedge clk_i);
                tx_o <= fr[i];
                repeat (BIT_CYCLES - 1) @(posedge clk_i);
            end
        end
    endtask : send_str
    // Samples mid-bit, least significant bit first, one stop bit.
    always begin : rx_proc
        @(negedge rx_i);
        repeat (BIT_CYCLES / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_i);
            rx_byte[i] = rx_i;
        end
        repeat (BIT_CYCLES) @(posedge clk_i);
        if (rx_cnt == 0) rx_first = rx_byte;
        rx_last = rx_byte;
        if (rx_cnt < 32) rx_buf[rx_cnt] = rx_byte;
        rx_cnt++;
    end
endmodule : pdc_host_model

// >>> pump_drive_command_parser_test.sv
// Self-checking bench for the pump drive command parser.
`timescale 1ns/1ns
module pump_drive_command_parser_test
    import pdc_pkg::*;
;
    localparam int BITC = 16;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [BTN_N-1:0] btn = 7'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [8:0] nvm_f = 9'h064;
    logic [8:0] nvm_a = 9'h0c8;
    logic [1:0] nvm_w = 2'h1;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, rd_val;
    logic rx, tx, nvm_wr, run, lamp;
    logic [8:0] freq, amp;
    logic [1:0] wave;
    int miscompares = 0;
    int cmp_count = 0;
    int n0;
    string wv[3] = '{{"M", "S", "\r"}, {"M", "R", "\r"}, "MC\r"};
    always #5 sys_clk = ~sys_clk;
    pdc_pump_drive_command_parser #(.BIT_CYCLES(BITC)) u_dut (
        .sys_clk_i(sys_clk), .srst_i(srst), .btn_i(btn), .uart_rx_i(rx), .uart_tx_o(tx),
        .nvm_freq_i(nvm_f), .nvm_amp_i(nvm_a), .nvm_wave_i(nvm_w), .nvm_wr_o(nvm_wr),
        .freq_o(freq), .amp_o(amp), .wave_o(wave), .pump_run_o(run), .lamp_o(lamp),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
    pdc_host_model #(.BIT_CYCLES(BITC)) u_host (.clk_i(sys_clk), .rx_i(tx), .tx_o(rx));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_set(input logic [8:0] f, a, input logic [1:0] w, input logic r);
        chk("freq", 32'(f), 32'(freq));
        chk("amp", 32'(a), 32'(amp));
        chk("wave", 32'(w), 32'(wave));
        chk("run", 32'(r), 32'(run));
        chk("lamp", 32'(r), 32'(lamp));
    endtask : chk_set
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : reg_read
    task automatic press(input int b);
        @(posedge sys_clk);
        btn[b] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        btn[b] <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : press
    task automatic cmd(input string s);
        u_host.send_str(s);
        repeat (8) @(posedge sys_clk);
    endtask : cmd
    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_set(9'h064, 9'h0c8, 2'h1, 1'b0);
        reg_read(REG_SETTING, rd_val);
        chk("setting", 32'h00c8_0064, rd_val);
        reg_read(REG_STATUS, rd_val);
        chk("status", 32'h4, rd_val);
        reg_read(4'hc, rd_val);
        chk("unmapped", 32'h0, rd_val);
        press(BTN_POWER);
        chk_set(9'h064, 9'h0c8, 2'h1, 1'b1);
        press(BTN_FUP);
        press(BTN_FUP);
        press(BTN_FDN);
        press(BTN_AUP);
        chk_set(9'h065, 9'h0c9, 2'h1, 1'b1);
        for (int i = 0; i < 3; i++) begin
            press(BTN_WAVE);
            chk("wave step", 32'((i + 2) % 3), 32'(wave));
        end
        @(posedge sys_clk);
        btn[BTN_STORE] <= 1'b1;
        for (n0 = 0; n0 < 30 && nvm_wr !== 1'b1; n0++) @(negedge sys_clk);
        chk("store freq", 32'h65, 32'(freq));
        if (n0 == 30) begin
            miscompares++;
            wrap_up;
        end
        @(posedge sys_clk);
        btn[BTN_STORE] <= 1'b0;
        cmd("boff\r");
        chk("run off", 32'h0, 32'(run));
        reg_write(REG_CTRL, 32'h1);
        press(BTN_POWER);
        chk("run panel off", 32'h0, 32'(run));
        reg_write(REG_CTRL, 32'h2);
        cmd("bon\r");
        chk("run masked", 32'h0, 32'(run));
        reg_write(REG_CTRL, 32'h3);
        cmd("bon\r");
        chk("run on", 32'h1, 32'(run));
        cmd("F300\r");
        press(BTN_FUP);
        chk("freq top", 32'h12c, 32'(freq));
        cmd("F301\rF0\rFx\rQ\r");
        chk("freq kept", 32'h12c, 32'(freq));
        cmd("F1\r");
        chk("freq low", 32'h1, 32'(freq));
        cmd("A100,5\r");
        chk("amp frac", 32'hc9, 32'(amp));
        cmd("A4,5\rA251\r");
        chk("amp kept", 32'hc9, 32'(amp));
        cmd("A5\r");
        chk("amp low", 32'ha, 32'(amp));
        foreach (wv[i]) begin
            cmd(wv[i]);
            chk("wave cmd", 32'(2 - i), 32'(wave));
        end
        chk("run kept", 32'h1, 32'(run));
        n0 = u_host.rx_cnt;
        cmd("F12");
        chk("freq wait", 32'h1, 32'(freq));
        cmd("\r");
        chk("freq set", 32'hc, 32'(freq));
        chk("no report", 32'(n0), 32'(u_host.rx_cnt));
        cmd("\r");
        for (int t = 0; t < 4000 && u_host.rx_cnt < n0 + 19; t++) @(posedge sys_clk);
        repeat (200) @(posedge sys_clk);
        chk("report len", 32'(n0 + 19), 32'(u_host.rx_cnt));
        chk("report head", 32'(CH_UF), 32'(u_host.rx_first));
        chk("report tail", 32'(CH_LF), 32'(u_host.rx_last));
        chk("report freq", 32'("012"),
            32'({u_host.rx_buf[1], u_host.rx_buf[2], u_host.rx_buf[3]}));
        chk("report wave run", {16'h0, CH_UC, CH_1},
            {16'h0, u_host.rx_buf[13], u_host.rx_buf[16]});
        nvm_f <= 9'h12d;
        nvm_a <= 9'h1f5;
        nvm_w <= 2'h3;
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_set(9'h000, 9'h000, 2'h0, 1'b0);
        wrap_up;
    end
endmodule : pump_drive_command_parser_test
